/* File: core/rcw_consts.vh */
// Constants for the radio configuration and wake-up timer register bank.
// Assumes a 100 MHz core clock and a register index that is the byte address over four.
`ifndef RCW_CONSTS_VH
`define RCW_CONSTS_VH
// ==========================================================================
// Register indices, byte address is four times the index.
`define RCW_IDX_BYPASS 10'h107
`define RCW_IDX_TXDLY 10'h10a
`define RCW_IDX_EXT 10'h10b
`define RCW_IDX_FMT 10'h13e
`define RCW_IDX_CHLO 10'h300
`define RCW_IDX_CHMI 10'h301
`define RCW_IDX_CHHI 10'h302
`define RCW_IDX_TXMOD 10'h306
`define RCW_IDX_RSSI 10'h30c
`define RCW_IDX_SQI 10'h30d
`define RCW_IDX_PRAM 10'h313
`define RCW_IDX_TXBASE 10'h314
`define RCW_IDX_RXBASE 10'h315
`define RCW_IDX_PRESC 10'h316
`define RCW_IDX_SLEEP 10'h317
`define RCW_IDX_RLDHI 10'h318
`define RCW_IDX_RLDLO 10'h319
`define RCW_IDX_TMRCTL 10'h31a
`define RCW_IDX_STATUS 10'h31b
// ==========================================================================
// Reset values.
`define RCW_RST_TXDLY 8'hc0
`define RCW_RST_EXT 8'h00
`define RCW_RST_FMT 8'h00
`define RCW_RST_CHLO 8'h80
`define RCW_RST_CHMI 8'ha9
`define RCW_RST_CHHI 8'h03
`define RCW_RST_PREEMP 1'b1
`define RCW_RST_TXBASE 8'h80
`define RCW_RST_RXBASE 8'h00
// ==========================================================================
// Field positions.
`define RCW_BIT_BYPASS 7
`define RCW_SLEEP_HI 6
`define RCW_SLEEP_LO 3
`define RCW_BIT_WAKE 0
`define RCW_BIT_FLAGRST 0
`define RCW_BIT_CAL 1
`define RCW_BIT_TOFLAG 1
`define RCW_BIT_PORFLAG 2
`define RCW_BIT_XOSCRDY 4
`define RCW_BIT_CALRDY 5
// ==========================================================================
// Frame formats and sleep states.
`define RCW_FMT_PACKET 8'h00
`define RCW_FMT_RAW_RX 8'h02
`define RCW_FMT_RAW_TX 8'h03
`define RCW_SLEEP_RETAIN_RAM 4'h1
`define RCW_SLEEP_CRYSTAL_ON 4'h4
`define RCW_SLEEP_RAM_AND_CRYSTAL 4'h5
`define RCW_SLEEP_RAM_AND_RC_OSC 4'hb
// ==========================================================================
// Timing.
`define RCW_CLK_PERIOD_NS 10
`define RCW_TX_STEP_NS 1000
`define RCW_EXT_STEP_NS 4000
`define RCW_TX_STEP_CYC (`RCW_TX_STEP_NS / `RCW_CLK_PERIOD_NS)
`define RCW_EXT_STEP_CYC (`RCW_EXT_STEP_NS / `RCW_CLK_PERIOD_NS)
`endif

/* File: core/rcw_radio_config_regs.v */
// Radio configuration bank with MAC entry delays and the wake-up timer.
// Assumes an APB master on core_clk and a slow 32 kHz clock sampled as a pin.
//
// Contract
// - Transmit entry waits programmable 1 us steps.
// - Extension adds 4 us steps both directions.
// - Format field selects packet or raw modes.
// - Channel word is 24 bits over three registers.
// - Bit zero enables transmit preemphasis, reset on.
// - Upper seven modulation bits belong to controller.
// - Received power reads as signed byte.
// - Link quality readback, reset zero.
// - Transmit area base pointer, reset 128.
// - Receive area base pointer, reset zero.
// - Prescaler code divides slow clock by table.
// - New prescaler applies on sleep register write.
// - Sleep field selects retention state.
// - Wake on timeout only when enabled.
// - Calibration enable starts slow RC calibration.
// - Flag reset clears timeout and cold-start flags.
// - Bypass bit skips both entry delays.
// - Timeout flag latches until cleared.
`include "rcw_consts.vh"
`default_nettype none

module rcw_radio_config_regs
#(
  parameter AW = 12
)
(
  input wire core_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire transmitCommand,
  input wire receiveCommand,
  output reg txEnter,
  output reg rxStart,
  output reg [7:0] frameFormatSelect,
  output reg rawSymbolPortRx,
  output reg rawSymbolPortTx,
  output reg [23:0] channelFrequencyWord,
  output reg txPreemphasisEnable,
  input wire [6:0] controllerOwnedBits,
  input wire [7:0] rssiIn,
  input wire [7:0] sqiIn,
  input wire linkValid,
  output reg [3:0] pramPage,
  output reg [7:0] txBufferBase,
  output reg [7:0] rxBufferBase,
  output reg [3:0] sleepState,
  output reg sleepRetainRam,
  output reg sleepCrystalOn,
  output reg sleepRcOsc,
  output reg slowRcCalibrateEnable,
  input wire slowRcCalDone,
  input wire slowCrystalReady,
  input wire slowClkPin,
  output reg wakeRequest
);

  localparam ST_IDLE = 2'd0;
  localparam ST_TXW = 2'd1;
  localparam ST_RXW = 2'd2;

  // ==========================================================================
  // Register state.
  reg [7:0] txDelay_q;
  reg [7:0] extDelay_q;
  reg bypass_q;
  reg [7:0] rssi_q;
  reg [7:0] sqi_q;
  reg [2:0] prescStage_q;
  reg [2:0] prescAct_q;
  reg wakeOnTimeout_q;
  reg [7:0] reloadHigh_q;
  reg [15:0] reload_q;
  reg reloadLoad_q;
  reg timeoutFlag_q;
  reg porFlag_q;
  reg started_q;
  reg [1:0] state_q;
  reg [17:0] delayCnt_q;
  reg [2:0] slowSync_q;
  reg slowLevel_q;
  reg [15:0] prescCnt_q;
  reg [15:0] timer_q;

  // ==========================================================================
  // Bus decode.
  wire [9:0] idx = paddr[11:2];
  wire setupAcc = psel & penable & ~pready;
  wire acc = psel & penable & pready;
  wire wrAcc = acc & pwrite;
  wire [7:0] wd = pwdata[7:0];
  reg [7:0] rdByte;
  reg hit;

  always @*
  begin
    hit = 1'b1;
    rdByte = 8'h00;
    if (idx == `RCW_IDX_BYPASS)
      rdByte = {bypass_q, 7'h00};
    else if (idx == `RCW_IDX_TXDLY)
      rdByte = txDelay_q;
    else if (idx == `RCW_IDX_EXT)
      rdByte = extDelay_q;
    else if (idx == `RCW_IDX_FMT)
      rdByte = frameFormatSelect;
    else if (idx == `RCW_IDX_CHLO)
      rdByte = channelFrequencyWord[7:0];
    else if (idx == `RCW_IDX_CHMI)
      rdByte = channelFrequencyWord[15:8];
    else if (idx == `RCW_IDX_CHHI)
      rdByte = channelFrequencyWord[23:16];
    else if (idx == `RCW_IDX_TXMOD)
      rdByte = {controllerOwnedBits, txPreemphasisEnable};
    else if (idx == `RCW_IDX_RSSI)
      rdByte = rssi_q;
    else if (idx == `RCW_IDX_SQI)
      rdByte = sqi_q;
    else if (idx == `RCW_IDX_PRAM)
      rdByte = {4'h0, pramPage};
    else if (idx == `RCW_IDX_TXBASE)
      rdByte = txBufferBase;
    else if (idx == `RCW_IDX_RXBASE)
      rdByte = rxBufferBase;
    else if (idx == `RCW_IDX_PRESC)
      rdByte = 8'h00;
    else if (idx == `RCW_IDX_SLEEP)
      rdByte = {1'b0, sleepState, 2'b00, wakeOnTimeout_q};
    else if (idx == `RCW_IDX_RLDHI)
      rdByte = 8'h00;
    else if (idx == `RCW_IDX_RLDLO)
      rdByte = reload_q[7:0];
    else if (idx == `RCW_IDX_TMRCTL)
      rdByte = {6'h00, slowRcCalibrateEnable, 1'b0};
    else if (idx == `RCW_IDX_STATUS)
      rdByte = {2'b00, slowRcCalDone, slowCrystalReady, 1'b0, porFlag_q, timeoutFlag_q, 1'b0};
    else
      hit = 1'b0;
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setupAcc;
      pslverr <= setupAcc & ~hit;
      if (setupAcc && !pwrite)
        prdata <= {24'h000000, rdByte};
    end
  end

  // ==========================================================================
  // Software registers.
  wire wTx = wrAcc & hit & (idx == `RCW_IDX_TXDLY);
  wire wLo = wrAcc & hit & (idx == `RCW_IDX_RLDLO);
  wire wSleep = wrAcc & hit & (idx == `RCW_IDX_SLEEP);
  wire wCtl = wrAcc & hit & (idx == `RCW_IDX_TMRCTL);
  wire flagClear = wCtl & wd[`RCW_BIT_FLAGRST];

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bypass_q <= 1'b0;
      txDelay_q <= `RCW_RST_TXDLY;
      extDelay_q <= `RCW_RST_EXT;
      frameFormatSelect <= `RCW_RST_FMT;
      channelFrequencyWord <= {`RCW_RST_CHHI, `RCW_RST_CHMI, `RCW_RST_CHLO};
      txPreemphasisEnable <= `RCW_RST_PREEMP;
      pramPage <= 4'h0;
      txBufferBase <= `RCW_RST_TXBASE;
      rxBufferBase <= `RCW_RST_RXBASE;
      prescStage_q <= 3'd0;
      prescAct_q <= 3'd0;
      sleepState <= 4'h0;
      wakeOnTimeout_q <= 1'b0;
      reloadHigh_q <= 8'h00;
      reload_q <= 16'h0000;
      reloadLoad_q <= 1'b0;
      slowRcCalibrateEnable <= 1'b0;
    end
    else
    begin
      reloadLoad_q <= wLo;
      if (wrAcc && hit)
      begin
        if (idx == `RCW_IDX_BYPASS)
          bypass_q <= wd[`RCW_BIT_BYPASS];
        else if (wTx)
          txDelay_q <= wd;
        else if (idx == `RCW_IDX_EXT)
          extDelay_q <= wd;
        else if (idx == `RCW_IDX_FMT)
          frameFormatSelect <= wd;
        else if (idx == `RCW_IDX_CHLO)
          channelFrequencyWord[7:0] <= wd;
        else if (idx == `RCW_IDX_CHMI)
          channelFrequencyWord[15:8] <= wd;
        else if (idx == `RCW_IDX_CHHI)
          channelFrequencyWord[23:16] <= wd;
        else if (idx == `RCW_IDX_TXMOD)
          txPreemphasisEnable <= wd[0];
        else if (idx == `RCW_IDX_PRAM)
          pramPage <= wd[3:0];
        else if (idx == `RCW_IDX_TXBASE)
          txBufferBase <= wd;
        else if (idx == `RCW_IDX_RXBASE)
          rxBufferBase <= wd;
        else if (idx == `RCW_IDX_PRESC)
          prescStage_q <= wd[2:0];
        else if (wSleep)
        begin
          sleepState <= wd[`RCW_SLEEP_HI:`RCW_SLEEP_LO];
          wakeOnTimeout_q <= wd[`RCW_BIT_WAKE];
          prescAct_q <= prescStage_q;
        end
        else if (idx == `RCW_IDX_RLDHI)
          reloadHigh_q <= wd;
        else if (wLo)
          reload_q <= {reloadHigh_q, wd};
        else if (wCtl)
          slowRcCalibrateEnable <= wd[`RCW_BIT_CAL];
      end
    end
  end

  // ==========================================================================
  // Decoded mode outputs and readback capture.
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rawSymbolPortRx <= 1'b0;
      rawSymbolPortTx <= 1'b0;
      sleepRetainRam <= 1'b0;
      sleepCrystalOn <= 1'b0;
      sleepRcOsc <= 1'b0;
      rssi_q <= 8'h00;
      sqi_q <= 8'h00;
    end
    else
    begin
      rawSymbolPortRx <= (frameFormatSelect == `RCW_FMT_RAW_RX);
      rawSymbolPortTx <= (frameFormatSelect == `RCW_FMT_RAW_TX);
      sleepRetainRam <= (sleepState == `RCW_SLEEP_RETAIN_RAM) | (sleepState == `RCW_SLEEP_RAM_AND_CRYSTAL) |
        (sleepState == `RCW_SLEEP_RAM_AND_RC_OSC);
      sleepCrystalOn <= (sleepState == `RCW_SLEEP_CRYSTAL_ON) | (sleepState == `RCW_SLEEP_RAM_AND_CRYSTAL);
      sleepRcOsc <= (sleepState == `RCW_SLEEP_RAM_AND_RC_OSC);
      if (linkValid)
      begin
        rssi_q <= rssiIn;
        sqi_q <= sqiIn;
      end
    end
  end

  // ==========================================================================
  // Transmit and receive entry delays.
  wire [31:0] txCyclesFull = txDelay_q * `RCW_TX_STEP_CYC + extDelay_q * `RCW_EXT_STEP_CYC;
  wire [31:0] rxCyclesFull = extDelay_q * `RCW_EXT_STEP_CYC;
  wire [17:0] txCycles = txCyclesFull[17:0];
  wire [17:0] rxCycles = rxCyclesFull[17:0];

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      delayCnt_q <= 18'h00000;
      txEnter <= 1'b0;
      rxStart <= 1'b0;
    end
    else
    begin
      txEnter <= 1'b0;
      rxStart <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (transmitCommand)
          begin
            if (bypass_q || txCycles == 18'h00000)
              txEnter <= 1'b1;
            else
            begin
              state_q <= ST_TXW;
              delayCnt_q <= txCycles - 18'h00001;
            end
          end
          else if (receiveCommand)
          begin
            if (bypass_q || rxCycles == 18'h00000)
              rxStart <= 1'b1;
            else
            begin
              state_q <= ST_RXW;
              delayCnt_q <= rxCycles - 18'h00001;
            end
          end
        end
        ST_TXW, ST_RXW:
        begin
          if (delayCnt_q == 18'h00000)
          begin
            txEnter <= (state_q == ST_TXW);
            rxStart <= (state_q == ST_RXW);
            state_q <= ST_IDLE;
          end
          else
            delayCnt_q <= delayCnt_q - 18'h00001;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Slow clock sampling and prescaler.
  wire slowAgree = (slowSync_q[1] == slowSync_q[2]);
  wire slowRise = slowAgree & slowSync_q[2] & ~slowLevel_q;
  reg [15:0] prescMax;

  always @*
  begin
    case (prescAct_q)
      3'd0: prescMax = 16'h0000;
      3'd1: prescMax = 16'h0003;
      3'd2: prescMax = 16'h0007;
      3'd3: prescMax = 16'h000f;
      3'd4: prescMax = 16'h007f;
      3'd5: prescMax = 16'h03ff;
      3'd6: prescMax = 16'h1fff;
      default: prescMax = 16'hffff;
    endcase
  end

  wire prescTick = slowRise & (prescCnt_q >= prescMax);

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slowSync_q <= 3'b000;
      slowLevel_q <= 1'b0;
      prescCnt_q <= 16'h0000;
    end
    else
    begin
      slowSync_q <= {slowSync_q[1:0], slowClkPin};
      if (slowAgree)
        slowLevel_q <= slowSync_q[2];
      if (wSleep)
        prescCnt_q <= 16'h0000;
      else if (prescTick)
        prescCnt_q <= 16'h0000;
      else if (slowRise)
        prescCnt_q <= prescCnt_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Wake-up timer, flags and wake request.
  wire timeout = prescTick & ~reloadLoad_q & (timer_q == 16'h0000);

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_q <= 16'h0000;
      timeoutFlag_q <= 1'b0;
      porFlag_q <= 1'b0;
      started_q <= 1'b0;
      wakeRequest <= 1'b0;
    end
    else
    begin
      started_q <= 1'b1;
      if (reloadLoad_q || timeout)
        timer_q <= reload_q;
      else if (prescTick)
        timer_q <= timer_q - 16'h0001;
      if (timeout)
        timeoutFlag_q <= 1'b1;
      else if (flagClear)
        timeoutFlag_q <= 1'b0;
      if (!started_q)
        porFlag_q <= 1'b1;
      else if (flagClear)
        porFlag_q <= 1'b0;
      wakeRequest <= timeout & wakeOnTimeout_q;
    end
  end

endmodule // rcw_radio_config_regs

`default_nettype wire

/* File: test/rcw_radio_config_regs_chk.sv */
// Checker for the radio configuration register bank, bound to its top module.
// Assumes APB writes land at the edge where pready is sampled high.
`default_nettype none
module rcw_radio_config_regs_chk
#(
  parameter AW = 12
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] frameFormatSelect,
  input wire logic rawSymbolPortRx,
  input wire logic rawSymbolPortTx,
  input wire logic [23:0] channelFrequencyWord,
  input wire logic txPreemphasisEnable,
  input wire logic [7:0] txBufferBase,
  input wire logic [7:0] rxBufferBase,
  input wire logic [3:0] sleepState,
  input wire logic sleepRetainRam,
  input wire logic sleepRcOsc,
  input wire logic slowRcCalibrateEnable,
  input wire logic wakeRequest
);
  // ==========
  // Completed write and its register index.
  wire wrDone = psel && penable && pready && pwrite;
  wire [9:0] idx = paddr[11:2];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // ==========
  // Output relations.
  a_raw_rx_decode: assert property (rawSymbolPortRx == ($past(frameFormatSelect) == 8'h02))
    else $error("raw receive decode wrong");
  a_raw_tx_decode: assert property (rawSymbolPortTx == ($past(frameFormatSelect) == 8'h03))
    else $error("raw transmit decode wrong");
  a_sleep_decode: assert property (sleepRetainRam == ($past(sleepState) inside {4'h1, 4'h5, 4'hb})
    && sleepRcOsc == ($past(sleepState) == 4'hb)) else $error("sleep decode wrong");
  a_sleep_write: assert property ($changed(sleepState) |-> $past(wrDone && idx == 10'h317)
    && sleepState == $past(pwdata[6:3])) else $error("sleep field changed wrongly");
  a_chan_write: assert property ($changed(channelFrequencyWord[7:0]) |-> $past(wrDone && idx == 10'h300)
    && channelFrequencyWord[7:0] == $past(pwdata[7:0])) else $error("channel low byte changed wrongly");
  a_preemp_write: assert property ($changed(txPreemphasisEnable) |-> $past(wrDone && idx == 10'h306)
    && txPreemphasisEnable == $past(pwdata[0])) else $error("preemphasis changed wrongly");
  a_txbase_write: assert property ($changed(txBufferBase) |-> $past(wrDone && idx == 10'h314)
    && txBufferBase == $past(pwdata[7:0])) else $error("transmit base changed wrongly");
  a_rxbase_write: assert property ($changed(rxBufferBase) |-> $past(wrDone && idx == 10'h315)
    && rxBufferBase == $past(pwdata[7:0])) else $error("receive base changed wrongly");
  a_cal_write: assert property ($changed(slowRcCalibrateEnable) |-> $past(wrDone && idx == 10'h31a)
    && slowRcCalibrateEnable == $past(pwdata[1])) else $error("calibration enable changed wrongly");
  a_wake_pulse: assert property (wakeRequest |=> !wakeRequest)
    else $error("wake request longer than one cycle");
endmodule // rcw_radio_config_regs_chk

bind rcw_radio_config_regs rcw_radio_config_regs_chk #(.AW(AW)) u_chk (.core_clk(core_clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .frameFormatSelect(frameFormatSelect), .rawSymbolPortRx(rawSymbolPortRx), .rawSymbolPortTx(rawSymbolPortTx),
  .channelFrequencyWord(channelFrequencyWord), .txPreemphasisEnable(txPreemphasisEnable),
  .txBufferBase(txBufferBase), .rxBufferBase(rxBufferBase), .sleepState(sleepState),
  .sleepRetainRam(sleepRetainRam), .sleepRcOsc(sleepRcOsc), .slowRcCalibrateEnable(slowRcCalibrateEnable),
  .wakeRequest(wakeRequest));
`default_nettype wire

/* File: test/rcw_radio_config_regs_tb.sv */
// Self-checking bench for the radio configuration register bank.
// Assumes one APB wait state and the checker bound beside the bank.
`default_nettype none
module rcw_radio_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Ports and bench state.
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic transmitCommand = 1'b0;
  logic receiveCommand = 1'b0;
  logic [6:0] controllerOwnedBits = 7'h00;
  logic [7:0] rssiIn = 8'h00;
  logic [7:0] sqiIn = 8'h00;
  logic linkValid = 1'b0;
  logic slowRcCalDone = 1'b0;
  logic slowCrystalReady = 1'b0;
  logic slowClkPin = 1'b0;
  logic slowRun = 1'b0;
  logic pready, pslverr, txEnter, rxStart, rawSymbolPortRx, rawSymbolPortTx, txPreemphasisEnable, rdErr;
  logic sleepRetainRam, sleepCrystalOn, sleepRcOsc, slowRcCalibrateEnable, wakeRequest;
  logic [7:0] frameFormatSelect, txBufferBase, rxBufferBase;
  logic [23:0] channelFrequencyWord;
  logic [3:0] pramPage, sleepState;
  logic [31:0] prdata, rdData;
  logic [7:0] mdl [int];
  integer seed;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  int wIdx [11] = '{'h10a, 'h10b, 'h13e, 'h300, 'h301, 'h302, 'h306, 'h313, 'h314, 'h315, 'h107};
  logic [7:0] wMask [11] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h0f, 8'hff, 8'hff, 8'h80};
  int dTab [6][5] = '{'{3, 1, 0, 1, 701}, '{2, 0, 0, 1, 201}, '{0, 0, 0, 1, 1}, '{3, 1, 1, 1, 1},
    '{9, 1, 0, 0, 401}, '{9, 1, 1, 0, 1}};
  int fmts [5] = '{0, 2, 3, 1, 255};
  int slp [5] = '{1, 4, 5, 11, 2};

  rcw_radio_config_regs #(.AW(12)) u_rcw_radio_config_regs (.core_clk(clk), .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .transmitCommand, .receiveCommand, .txEnter, .rxStart,
    .frameFormatSelect, .rawSymbolPortRx, .rawSymbolPortTx, .channelFrequencyWord, .txPreemphasisEnable,
    .controllerOwnedBits, .rssiIn, .sqiIn, .linkValid, .pramPage, .txBufferBase, .rxBufferBase, .sleepState,
    .sleepRetainRam, .sleepCrystalOn, .sleepRcOsc, .slowRcCalibrateEnable, .slowRcCalDone, .slowCrystalReady,
    .slowClkPin, .wakeRequest);

  always #5 clk = ~clk;
  always #52 if (slowRun) slowClkPin = ~slowClkPin;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      print_verdict();
    end
  end
  // ==========
  // Bus cycles, comparison and verdict.
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input int idx, input logic wr, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 12'(idx * 4);
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrM(input int idx, input logic [7:0] v, input logic [7:0] m);
    apb(idx, 1'b1, v);
    mdl[idx] = v & m;
  endtask

  task automatic rdChk(input int idx, input logic [7:0] e);
    apb(idx, 1'b0, 8'h00);
    chk($sformatf("reg %h", idx), {9'h000, 16'h0000, e}, {rdErr, rdData});
  endtask

  function automatic logic [7:0] expOf(input int i);
    return (i == 'h306) ? {controllerOwnedBits, mdl[i][0]} : mdl[i];
  endfunction
  // ==========
  // Main sequence.
  initial
  begin
    seed = 32'hbbcd84ee;
    rssiIn <= 8'($random(seed));
    sqiIn <= 8'($random(seed));
    controllerOwnedBits <= 7'($random(seed));
    mdl = '{'h107: 8'h00, 'h10a: 8'hc0, 'h10b: 8'h00, 'h13e: 8'h00, 'h300: 8'h80, 'h301: 8'ha9, 'h302: 8'h03,
      'h306: 8'h01, 'h30c: 8'h00, 'h30d: 8'h00, 'h313: 8'h00, 'h314: 8'h80, 'h315: 8'h00, 'h316: 8'h00,
      'h317: 8'h00, 'h318: 8'h00, 'h31a: 8'h00, 'h31b: 8'h04};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (mdl[i]) rdChk(i, expOf(i));
    foreach (wIdx[k]) wrM(wIdx[k], 8'($random(seed)), wMask[k]);
    controllerOwnedBits <= 7'($random(seed));
    foreach (mdl[i]) rdChk(i, expOf(i));
    chk("chanWord", {9'h000, mdl['h302], mdl['h301], mdl['h300]}, {9'h000, channelFrequencyWord});
    chk("ptrs", {mdl['h314], mdl['h315], mdl['h313][3:0], mdl['h306][0]},
      {txBufferBase, rxBufferBase, pramPage, txPreemphasisEnable});
    apb('h3ff, 1'b1, 8'h55);
    apb('h000, 1'b0, 8'h00);
    chk("unmapped", {1'b1, 32'h0}, {rdErr, rdData});
    wrM('h316, 8'h07, 8'h00);
    wrM('h318, 8'h5a, 8'h00);
    rdChk('h316, 8'h00);
    rdChk('h318, 8'h00);
    foreach (dTab[k])
    begin
      wrM('h10a, 8'(dTab[k][0]), 8'hff);
      wrM('h10b, 8'(dTab[k][1]), 8'hff);
      wrM('h107, 8'(dTab[k][2] * 128), 8'h80);
      transmitCommand <= (dTab[k][3] == 1);
      receiveCommand <= (dTab[k][3] == 0);
      @(posedge clk);
      transmitCommand <= 1'b0;
      receiveCommand <= 1'b0;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while ((dTab[k][3] == 1 ? txEnter : rxStart) !== 1'b1 && n < 3000);
      chk("entryDelay", dTab[k][4], n);
    end
    foreach (fmts[k])
    begin
      wrM('h13e, 8'(fmts[k]), 8'hff);
      @(posedge clk);
      chk("rawPort", {fmts[k] == 2, fmts[k] == 3}, {rawSymbolPortRx, rawSymbolPortTx});
    end
    foreach (slp[k])
    begin
      wrM('h317, 8'(slp[k] * 8), 8'h79);
      @(posedge clk);
      chk("sleep", {4'(slp[k]), (slp[k] inside {1, 5, 11}), (slp[k] inside {4, 5}), (slp[k] == 11)},
        {sleepState, sleepRetainRam, sleepCrystalOn, sleepRcOsc});
    end
    linkValid <= 1'b1;
    @(posedge clk);
    linkValid <= 1'b0;
    mdl['h30c] = rssiIn;
    mdl['h30d] = sqiIn;
    rssiIn <= ~rssiIn;
    sqiIn <= ~sqiIn;
    rdChk('h30c, mdl['h30c]);
    rdChk('h30d, mdl['h30d]);
    slowCrystalReady <= 1'b1;
    wrM('h316, 8'h00, 8'h00);
    wrM('h317, 8'h01, 8'h79);
    wrM('h318, 8'h00, 8'h00);
    wrM('h319, 8'h02, 8'hff);
    slowRun = 1'b1;
    n = 0;
    while (wakeRequest !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    chk("wakeSeen", 1, n < 2000);
    slowRun = 1'b0;
    repeat (10) @(posedge clk);
    rdChk('h31b, 8'h16);
    wrM('h31a, 8'h03, 8'h02);
    rdChk('h31b, 8'h10);
    rdChk('h31a, 8'h02);
    chk("calEnable", 1, slowRcCalibrateEnable);
    wrM('h317, 8'h00, 8'h79);
    slowRun = 1'b1;
    n = 0;
    repeat (150)
    begin
      @(posedge clk);
      n += (wakeRequest === 1'b1);
    end
    slowRun = 1'b0;
    chk("wakeMasked", 0, n);
    repeat (10) @(posedge clk);
    rdChk('h31b, 8'h12);
    wrM('h316, 8'h01, 8'h00);
    wrM('h317, 8'h01, 8'h79);
    slowRun = 1'b1;
    n = 0;
    while (wakeRequest !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wakeRequest !== 1'b1 && n < 2000);
    slowRun = 1'b0;
    chk("wakePeriod", 1, (n >= 124) && (n <= 125));
    print_verdict();
  end
endmodule // rcw_radio_config_regs_tb
`default_nettype wire
